// *** sdmrd_cmd_if.sv ***
/*
 * Interface carrying the decoded command from the decoder leaf to the
 * main module.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface sdmrd_cmd_if;
	sdmrd_pkg::sdmrd_cmd_e cmd;
	logic                  cke_prev;

	modport dec (output cmd, output cke_prev);
	modport use_side (input cmd, input cke_prev);
endinterface

// *** sdmrd_ctrl_model.sv ***
/*
 * Memory controller model driving the decoder's device pins.
 * Assumes the bench calls its tasks; pins move on falling mclk.
 */
`timescale 1ns/1ps
module sdmrd_ctrl_model
(
	// clock
	input  wire logic  mclk,
	// device pins
	output logic       reset_n,
	output logic       cke,
	output logic       cs_n,
	output logic       ras_n,
	output logic       cas_n,
	output logic       we_n,
	output logic [2:0] ba,
	output logic [15:0] addr
);
	// idle pins at time zero
	initial
	begin
		reset_n = 1'b1;
		{cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
		ba = 3'h0;
		addr = 16'h0000;
	end
	// one command held for two edges, since the pin filter drops any
	// change that lasts a single edge; then deselect with ras, cas, we, bank and address inverted
	task automatic cmd(input logic [4:0] s, input logic [2:0] b,
		input logic [15:0] a);
		@(negedge mclk);
		{cke, cs_n, ras_n, cas_n, we_n} = s;
		ba = b;
		addr = a;
		repeat (2) @(negedge mclk);
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = ~s[2:0];
		ba = ~b;
		addr = ~a;
	endtask
	// device reset pin held low for n cycles
	task automatic hit_reset(input int n);
		@(negedge mclk);
		reset_n = 1'b0;
		repeat (n) @(negedge mclk);
		reset_n = 1'b1;
	endtask
endmodule // sdmrd_ctrl_model

// *** sdmrd_decode.sv ***
/*
 * Command pin decoder: maps sampled strobes and clock enable to a code.
 * Assumes the strobes arrive already registered on mclk.
 */
`timescale 1ns/1ps
module sdmrd_decode
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// sampled command pins
	input  wire logic       cke,
	input  wire logic       cs_n,
	input  wire logic       ras_n,
	input  wire logic       cas_n,
	input  wire logic       we_n,
	// decoded result
	sdmrd_cmd_if.dec        cmd_o
);

	logic cke_prev_reg;

	// ---------------------------------------------------------------
	// previous clock enable
	// ---------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
			cke_prev_reg <= 1'b0;
		else
			cke_prev_reg <= cke;
	end

	// ---------------------------------------------------------------
	// truth table decode
	// ---------------------------------------------------------------
	wire logic [3:0] pins = {cs_n, ras_n, cas_n, we_n};
	wire logic       idle_pat = cs_n | (pins == 4'h7);

	function automatic sdmrd_pkg::sdmrd_cmd_e dec_fn(
		input logic       p, input logic c, input logic [3:0] s,
		input logic       ip);
		dec_fn = sdmrd_pkg::SDMRD_CMD_ILL;
		if (p & c)
		begin
			if (s[3])
				dec_fn = sdmrd_pkg::SDMRD_CMD_DES;
			else
				case (s[2:0])
					3'h7: dec_fn = sdmrd_pkg::SDMRD_CMD_NOP;
					3'h0: dec_fn = sdmrd_pkg::SDMRD_CMD_MRS;
					3'h1: dec_fn = sdmrd_pkg::SDMRD_CMD_REF;
					3'h2: dec_fn = sdmrd_pkg::SDMRD_CMD_PRE;
					3'h3: dec_fn = sdmrd_pkg::SDMRD_CMD_ACT;
					3'h4: dec_fn = sdmrd_pkg::SDMRD_CMD_WR;
					3'h5: dec_fn = sdmrd_pkg::SDMRD_CMD_RD;
					3'h6: dec_fn = sdmrd_pkg::SDMRD_CMD_ZQC;
					default: dec_fn = sdmrd_pkg::SDMRD_CMD_ILL;
				endcase
		end
		else if (p & ~c)
		begin
			if (s == 4'h1)
				dec_fn = sdmrd_pkg::SDMRD_CMD_SRE;
			else if (ip)
				dec_fn = sdmrd_pkg::SDMRD_CMD_PDE;
		end
		else if (~p & c)
		begin
			if (ip)
				dec_fn = sdmrd_pkg::SDMRD_CMD_PDX;
		end
		else
			dec_fn = sdmrd_pkg::SDMRD_CMD_DES;
	endfunction

	// decode uses rising-edge samples only
	assign cmd_o.cmd      = dec_fn(cke_prev_reg, cke, pins, idle_pat);
	assign cmd_o.cke_prev = cke_prev_reg;

endmodule // sdmrd_decode

// *** sdmrd_map.svh ***
/*
 * Constants for the command decoder: mode register field positions,
 * reset values and timing counts.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef SDMRD_MAP_SVH
`define SDMRD_MAP_SVH

// ---------------------------------------------------------------
// bank address codes selecting a mode register
// ---------------------------------------------------------------
`define SDMRD_BA_MR0        3'h0
`define SDMRD_BA_MR1        3'h1
`define SDMRD_BA_MR2        3'h2
`define SDMRD_BA_MR3        3'h3

// ---------------------------------------------------------------
// field positions within the address bus
// ---------------------------------------------------------------
`define SDMRD_MR2_PASR_LO   0
`define SDMRD_MR2_CWL_LO    3
`define SDMRD_MR2_ASR_BIT   6
`define SDMRD_MR2_SRT_BIT   7
`define SDMRD_MR2_RTTWR_LO  9
`define SDMRD_MR3_SEL_LO    0
`define SDMRD_MR3_MPR_BIT   2
`define SDMRD_MR1_AL_LO     3
`define SDMRD_MR1_WLV_BIT   7
`define SDMRD_AP_BIT        10
`define SDMRD_BC_BIT        12

// ---------------------------------------------------------------
// reset values and latency base
// ---------------------------------------------------------------
`define SDMRD_CWL_BASE      4'h5
`define SDMRD_RST_PASR      3'h0
`define SDMRD_RST_CWL       3'h0
`define SDMRD_RST_RTTWR     2'h0
`define SDMRD_RST_AL        2'h0

`endif

// *** sdmrd_pkg.sv ***
/*
 * Types shared by the command decoder modules.
 * Assumes nothing of its surroundings.
 */
package sdmrd_pkg;

	// ---------------------------------------------------------------
	// decoded command codes
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		SDMRD_CMD_DES  = 4'h0,
		SDMRD_CMD_NOP  = 4'h1,
		SDMRD_CMD_MRS  = 4'h2,
		SDMRD_CMD_REF  = 4'h3,
		SDMRD_CMD_SRE  = 4'h4,
		SDMRD_CMD_SRX  = 4'h5,
		SDMRD_CMD_PRE  = 4'h6,
		SDMRD_CMD_ACT  = 4'h7,
		SDMRD_CMD_WR   = 4'h8,
		SDMRD_CMD_RD   = 4'h9,
		SDMRD_CMD_ZQC  = 4'hA,
		SDMRD_CMD_PDE  = 4'hB,
		SDMRD_CMD_PDX  = 4'hC,
		SDMRD_CMD_ILL  = 4'hF
	} sdmrd_cmd_e;

	// ---------------------------------------------------------------
	// device power state, one-hot
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		SDMRD_ST_IDLE = 4'h1,
		SDMRD_ST_MPR  = 4'h2,
		SDMRD_ST_SREF = 4'h4,
		SDMRD_ST_PDN  = 4'h8
	} sdmrd_state_e;

endpackage

// *** sdmrd_top.sv ***
/*
 * Command decoder and mode register 2/3 handling of a DDR memory
 * device: decodes the command pins, holds write latency, termination,
 * refresh and calibration readout settings, and flags each access taken outside a running burst.
 * Assumes the controller drives all pins from its own clock; pins are
 * resynchronised onto mclk here.
 */
`timescale 1ns/1ps
`include "sdmrd_map.svh"
module sdmrd_top
#(
	parameter int ADDR_W  = 16,
	parameter int BANK_W  = 3,
	parameter int BURST_W = 4
)
(
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire logic               reset_n,
	// command pins
	input  wire logic               cke,
	input  wire logic               cs_n,
	input  wire logic               ras_n,
	input  wire logic               cas_n,
	input  wire logic               we_n,
	input  wire logic [BANK_W-1:0]  ba,
	input  wire logic [ADDR_W-1:0]  addr,
	// decoded access
	output logic                    rd_go,
	output logic                    wr_go,
	output logic                    mpr_rd_go,
	output logic                    auto_pre,
	output logic                    chop4,
	output logic [BANK_W-1:0]       acc_bank,
	output logic [ADDR_W-1:0]       acc_addr,
	output logic                    act_go,
	output logic                    pre_go,
	output logic                    pre_all,
	output logic                    ref_go,
	output logic                    zq_go,
	output logic                    zq_long,
	output logic                    cmd_bad,
	// mode settings
	output logic [2:0]              pasr_sel,
	output logic [3:0]              cwl_clk,
	output logic [4:0]              wl_clk,
	output logic                    asr_en,
	output logic                    srt_en,
	output logic [1:0]              rtt_wr_eff,
	output logic                    mpr_on,
	output logic [1:0]              mpr_sel,
	// state
	output logic                    sref_on,
	output logic                    pdn_on,
	output logic                    part_lost,
	output logic                    burst_busy
);

	// ---------------------------------------------------------------
	// pin synchroniser: three stages, change taken when 2nd and 3rd agree
	// ---------------------------------------------------------------
	localparam int PW = 5 + BANK_W + ADDR_W + 1;
	logic [PW-1:0] s1_reg;
	logic [PW-1:0] s2_reg;
	logic [PW-1:0] s3_reg;
	logic [PW-1:0] held_reg;
	wire  logic [PW-1:0] pin_now =
		{reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr};
	wire  logic [PW-1:0] agree = ~(s2_reg ^ s3_reg);
	wire  logic [PW-1:0] held_next = (s2_reg & agree) | (held_reg & ~agree);

	always_ff @(posedge mclk)
	begin
		s1_reg   <= pin_now;
		s2_reg   <= s1_reg;
		s3_reg   <= s2_reg;
		held_reg <= rst ? {1'b1, {(PW-1){1'b0}}} : held_next;
	end

	wire logic              p_rstn = held_reg[PW-1];
	wire logic              p_cke  = held_reg[PW-2];
	wire logic              p_cs   = held_reg[PW-3];
	wire logic              p_ras  = held_reg[PW-4];
	wire logic              p_cas  = held_reg[PW-5];
	wire logic              p_we   = held_reg[PW-6];
	wire logic [BANK_W-1:0] p_ba   = held_reg[ADDR_W +: BANK_W];
	wire logic [ADDR_W-1:0] p_a    = held_reg[ADDR_W-1:0];

	// device reset: controller reset or pin reset, any mode
	wire logic dev_rst = rst | ~p_rstn;

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	sdmrd_cmd_if dif ();

	sdmrd_decode u_dec
	(
		.mclk  (mclk),
		.rst   (dev_rst),
		.cke   (p_cke),
		.cs_n  (p_cs),
		.ras_n (p_ras),
		.cas_n (p_cas),
		.we_n  (p_we),
		.cmd_o (dif.dec)
	);

	wire sdmrd_pkg::sdmrd_cmd_e cmd = dif.cmd;

	// mode register select from bank bits
	wire logic is_mrs = cmd == sdmrd_pkg::SDMRD_CMD_MRS;
	wire logic mrs1 = is_mrs & (p_ba == `SDMRD_BA_MR1);
	wire logic mrs2 = is_mrs & (p_ba == `SDMRD_BA_MR2);
	wire logic mrs3 = is_mrs & (p_ba == `SDMRD_BA_MR3);

	// ---------------------------------------------------------------
	// state machine
	// ---------------------------------------------------------------
	sdmrd_pkg::sdmrd_state_e st_reg;
	sdmrd_pkg::sdmrd_state_e st_next;

	wire logic mpr_set = mrs3 & p_a[`SDMRD_MR3_MPR_BIT];
	wire logic mpr_clr = mrs3 & ~p_a[`SDMRD_MR3_MPR_BIT];

	always_comb
	begin
		st_next = st_reg;
		unique case (st_reg)
			sdmrd_pkg::SDMRD_ST_IDLE:
				if (cmd == sdmrd_pkg::SDMRD_CMD_SRE)
					st_next = sdmrd_pkg::SDMRD_ST_SREF;
				else if (cmd == sdmrd_pkg::SDMRD_CMD_PDE)
					st_next = sdmrd_pkg::SDMRD_ST_PDN;
				else if (mpr_set)
					st_next = sdmrd_pkg::SDMRD_ST_MPR;
			sdmrd_pkg::SDMRD_ST_MPR:
				if (mpr_clr)
					st_next = sdmrd_pkg::SDMRD_ST_IDLE;
			sdmrd_pkg::SDMRD_ST_SREF:
				if (cmd == sdmrd_pkg::SDMRD_CMD_PDX)
					st_next = sdmrd_pkg::SDMRD_ST_IDLE;
			sdmrd_pkg::SDMRD_ST_PDN:
				if (cmd == sdmrd_pkg::SDMRD_CMD_PDX)
					st_next = sdmrd_pkg::SDMRD_ST_IDLE;
			default:
				st_next = sdmrd_pkg::SDMRD_ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (dev_rst)
			st_reg <= sdmrd_pkg::SDMRD_ST_IDLE;
		else
			st_reg <= st_next;
	end

	// ---------------------------------------------------------------
	// mode register fields
	// ---------------------------------------------------------------
	logic [2:0] pasr_reg;
	logic [2:0] cwl_reg;
	logic       asr_reg;
	logic       srt_reg;
	logic [1:0] rttwr_reg;
	logic [1:0] mprsel_reg;
	logic [1:0] al_reg;
	logic       wlv_reg;

	always_ff @(posedge mclk)
	begin
		if (dev_rst)
		begin
			pasr_reg   <= `SDMRD_RST_PASR;
			cwl_reg    <= `SDMRD_RST_CWL;
			asr_reg    <= 1'b0;
			srt_reg    <= 1'b0;
			rttwr_reg  <= `SDMRD_RST_RTTWR;
			mprsel_reg <= 2'h0;
			al_reg     <= `SDMRD_RST_AL;
			wlv_reg    <= 1'b0;
		end
		else
		begin
			if (mrs2)
			begin
				pasr_reg  <= p_a[`SDMRD_MR2_PASR_LO +: 3];
				cwl_reg   <= p_a[`SDMRD_MR2_CWL_LO +: 3];
				asr_reg   <= p_a[`SDMRD_MR2_ASR_BIT];
				srt_reg   <= p_a[`SDMRD_MR2_SRT_BIT];
				rttwr_reg <= p_a[`SDMRD_MR2_RTTWR_LO +: 2];
			end
			// select bits only taken when readout mode is requested
			if (mpr_set)
				mprsel_reg <= p_a[`SDMRD_MR3_SEL_LO +: 2];
			if (mrs1)
			begin
				al_reg  <= p_a[`SDMRD_MR1_AL_LO +: 2];
				wlv_reg <= p_a[`SDMRD_MR1_WLV_BIT];
			end
		end
	end

	// whole-clock latencies; additive code 0/1/2 counted as clocks here
	wire logic [3:0] cwl_w = `SDMRD_CWL_BASE + {1'b0, cwl_reg};
	wire logic [4:0] wl_w  = {1'b0, cwl_w} + {3'h0, al_reg};

	// ---------------------------------------------------------------
	// burst guard: counts clocks of the accepted burst, two beats per clock
	// ---------------------------------------------------------------
	logic [BURST_W-1:0] burst_reg;
	wire  logic is_rd = cmd == sdmrd_pkg::SDMRD_CMD_RD;
	wire  logic is_wr = cmd == sdmrd_pkg::SDMRD_CMD_WR;
	wire  logic busy  = burst_reg != '0;
	// a new read or write only starts once the current burst is done
	wire  logic take_rw = (is_rd | is_wr) & ~busy;
	wire  logic bc4     = ~p_a[`SDMRD_BC_BIT];
	wire  logic [BURST_W-1:0] blen =
		bc4 ? BURST_W'(2) : BURST_W'(4);

	always_ff @(posedge mclk)
	begin
		if (dev_rst)
			burst_reg <= '0;
		else if (take_rw)
			burst_reg <= blen - BURST_W'(1);
		else if (busy)
			burst_reg <= burst_reg - BURST_W'(1);
	end

	// ---------------------------------------------------------------
	// registered outputs
	// ---------------------------------------------------------------
	wire logic in_mpr  = st_reg == sdmrd_pkg::SDMRD_ST_MPR;
	wire logic in_sref = st_reg == sdmrd_pkg::SDMRD_ST_SREF;
	wire logic pasr_on = pasr_reg != 3'h0;
	wire logic sre_now = cmd == sdmrd_pkg::SDMRD_CMD_SRE;
	// dynamic termination masked during write leveling
	wire logic [1:0] rtt_w = wlv_reg ? 2'h0 : rttwr_reg;

	always_ff @(posedge mclk)
	begin
		if (dev_rst)
		begin
			rd_go      <= 1'b0;
			wr_go      <= 1'b0;
			mpr_rd_go  <= 1'b0;
			auto_pre   <= 1'b0;
			chop4      <= 1'b0;
			acc_bank   <= '0;
			acc_addr   <= '0;
			act_go     <= 1'b0;
			pre_go     <= 1'b0;
			pre_all    <= 1'b0;
			ref_go     <= 1'b0;
			zq_go      <= 1'b0;
			zq_long    <= 1'b0;
			cmd_bad    <= 1'b0;
			part_lost  <= 1'b0;
		end
		else
		begin
			rd_go     <= take_rw & is_rd & ~in_mpr;
			mpr_rd_go <= take_rw & is_rd & in_mpr;
			wr_go     <= take_rw & is_wr;
			auto_pre  <= take_rw & p_a[`SDMRD_AP_BIT];
			chop4     <= take_rw & bc4;
			acc_bank  <= p_ba;
			acc_addr  <= p_a;
			act_go    <= cmd == sdmrd_pkg::SDMRD_CMD_ACT;
			pre_go    <= cmd == sdmrd_pkg::SDMRD_CMD_PRE;
			pre_all   <= (cmd == sdmrd_pkg::SDMRD_CMD_PRE)
				& p_a[`SDMRD_AP_BIT];
			ref_go    <= cmd == sdmrd_pkg::SDMRD_CMD_REF;
			zq_go     <= cmd == sdmrd_pkg::SDMRD_CMD_ZQC;
			zq_long   <= (cmd == sdmrd_pkg::SDMRD_CMD_ZQC)
				& p_a[`SDMRD_AP_BIT];
			cmd_bad   <= cmd == sdmrd_pkg::SDMRD_CMD_ILL;
			// sticky until reset; set by any self-refresh entry command while partial refresh is on, even in readout mode
			part_lost <= part_lost | (sre_now & pasr_on);
		end
	end

	// mode outputs
	always_ff @(posedge mclk)
	begin
		if (dev_rst)
		begin
			pasr_sel   <= 3'h0;
			cwl_clk    <= 4'h0;
			wl_clk     <= 5'h0;
			asr_en     <= 1'b0;
			srt_en     <= 1'b0;
			rtt_wr_eff <= 2'h0;
			mpr_on     <= 1'b0;
			mpr_sel    <= 2'h0;
			sref_on    <= 1'b0;
			pdn_on     <= 1'b0;
			burst_busy <= 1'b0;
		end
		else
		begin
			pasr_sel   <= pasr_reg;
			cwl_clk    <= cwl_w;
			wl_clk     <= wl_w;
			asr_en     <= asr_reg;
			srt_en     <= srt_reg;
			rtt_wr_eff <= rtt_w;
			mpr_on     <= in_mpr;
			mpr_sel    <= mprsel_reg;
			sref_on    <= in_sref;
			pdn_on     <= st_reg == sdmrd_pkg::SDMRD_ST_PDN;
			burst_busy <= busy;
		end
	end

endmodule // sdmrd_top

// *** sdmrd_top_props.sv ***
/*
 * Port checks for the command decoder top module.
 * Assumes binding into sdmrd_top, sharing its mclk and rst.
 */
`timescale 1ns/1ps
module sdmrd_top_props
#(
	parameter int ADDR_W = 16,
	parameter int BANK_W = 3
)
(
	// clock and reset
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic              reset_n,
	// command pins
	input wire logic              cke,
	input wire logic              cs_n,
	input wire logic              ras_n,
	input wire logic              cas_n,
	input wire logic              we_n,
	input wire logic [BANK_W-1:0] ba,
	input wire logic [ADDR_W-1:0] addr,
	// decoded access
	input wire logic              rd_go,
	input wire logic              wr_go,
	input wire logic              mpr_rd_go,
	input wire logic              auto_pre,
	input wire logic              chop4,
	input wire logic              zq_go,
	input wire logic              zq_long,
	input wire logic              burst_busy,
	// mode settings
	input wire logic [3:0]        cwl_clk,
	input wire logic [1:0]        rtt_wr_eff,
	input wire logic              mpr_on
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// -----------------------------------------------------------
	// pin patterns, clock enable high on both edges
	// -----------------------------------------------------------
	logic       cke_reg;
	logic [4:0] prev_reg;
	wire [3:0] pins   = {cs_n, ras_n, cas_n, we_n};
	wire       live   = reset_n && cke_reg && cke;
	// a command stays on the pins for two edges; only its first counts for reads and writes
	wire       fresh  = {live, pins} != prev_reg;
	always_ff @(posedge mclk)
	begin
		cke_reg  <= cke;
		prev_reg <= {live, pins};
	end
	wire       is_mrs = live && pins == 4'h0;
	wire       is_wr  = fresh && live && pins == 4'h4;
	wire       is_rd  = fresh && live && pins == 4'h5;
	wire       is_zq  = live && pins == 4'h6;
	// -----------------------------------------------------------
	// assertions
	// -----------------------------------------------------------
	a_wr_decode: assert property (is_wr |-> ##5 wr_go)
		else $error("write pattern not flagged");
	a_rd_decode: assert property (is_rd && !mpr_on |-> ##5 rd_go && !mpr_rd_go)
		else $error("read pattern not flagged");
	a_chop_bit: assert property (is_wr |-> ##5 chop4 == !$past(addr[12], 5))
		else $error("chop flag wrong");
	a_auto_pre: assert property (is_wr |-> ##5 auto_pre == $past(addr[10], 5))
		else $error("auto precharge flag wrong");
	a_cwl_field: assert property (is_mrs && ba == 3'h2 |->
		##6 cwl_clk == 4'h5 + {1'b0, $past(addr[5:3], 6)})
		else $error("write latency field wrong");
	a_mpr_enter: assert property (is_mrs && ba == 3'h3 |->
		##6 mpr_on == $past(addr[2], 6))
		else $error("readout mode not following bit 2");
	a_mpr_read: assert property (is_rd && mpr_on |-> ##5 mpr_rd_go && !rd_go)
		else $error("readout read went to array");
	a_wlvl_rtt: assert property (is_mrs && ba == 3'h1 && addr[7] |->
		##6 rtt_wr_eff == 2'h0)
		else $error("dynamic termination kept while leveling");
	a_burst_hold: assert property (wr_go && !chop4 |=> burst_busy [*3])
		else $error("eight beat burst not held");
	a_zq_len: assert property (is_zq |-> ##5 zq_go && zq_long == $past(addr[10], 5))
		else $error("calibration not flagged");
endmodule // sdmrd_top_props
bind sdmrd_top sdmrd_top_props #(.ADDR_W(ADDR_W), .BANK_W(BANK_W)) props_i (
	.mclk, .rst, .reset_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
	.rd_go, .wr_go, .mpr_rd_go, .auto_pre, .chop4, .zq_go, .zq_long,
	.burst_busy, .cwl_clk, .rtt_wr_eff, .mpr_on);

// *** sdmrd_top_tb.sv ***
/*
 * Self-checking bench for the command decoder top module.
 * Assumes the controller model drives every device pin.
 */
`timescale 1ns/1ps
module sdmrd_top_tb;
	// -----------------------------------------------------------
	// signals, patterns and counters
	// -----------------------------------------------------------
	logic        mclk = 1'b0;
	logic        rst  = 1'b1;
	logic        reset_n, cke, cs_n, ras_n, cas_n, we_n, rd_go, wr_go;
	logic        mpr_rd_go, auto_pre, chop4, act_go, pre_go, pre_all;
	logic        ref_go, zq_go, zq_long, cmd_bad, asr_en, srt_en, mpr_on;
	logic        sref_on, pdn_on, part_lost, burst_busy;
	logic [2:0]  ba, acc_bank, pasr_sel;
	logic [15:0] addr, acc_addr, cmd_a;
	logic [3:0]  cwl_clk;
	logic [4:0]  wl_clk;
	logic [1:0]  rtt_wr_eff, mpr_sel;
	int          error_cnt = 0;
	int          compares  = 0;
	// clock enable, then cs, ras, cas, we
	localparam logic [4:0] c_mrs = 5'h10, c_pre = 5'h12, c_wr = 5'h14;
	localparam logic [4:0] c_rd = 5'h15, c_nop = 5'h17, c_sre = 5'h01;
	logic [4:0] t_s [7] = '{5'h13, 5'h12, 5'h12, 5'h11, 5'h16, 5'h16,
		5'h00};
	logic [6:0] t_e [7] = '{7'h40, 7'h30, 7'h20, 7'h08, 7'h04, 7'h06,
		7'h01};
	always #2.5 mclk = ~mclk;
	sdmrd_top sdmrd_top_i (.mclk, .rst, .reset_n, .cke, .cs_n, .ras_n,
		.cas_n, .we_n, .ba, .addr, .rd_go, .wr_go, .mpr_rd_go, .auto_pre,
		.chop4, .acc_bank, .acc_addr, .act_go, .pre_go, .pre_all, .ref_go,
		.zq_go, .zq_long, .cmd_bad, .pasr_sel, .cwl_clk, .wl_clk, .asr_en,
		.srt_en, .rtt_wr_eff, .mpr_on, .mpr_sel, .sref_on, .pdn_on,
		.part_lost, .burst_busy);
	sdmrd_ctrl_model sdmrd_ctrl_model_i (.mclk, .reset_n, .cke, .cs_n,
		.ras_n, .cas_n, .we_n, .ba, .addr);
	// -----------------------------------------------------------
	// tasks
	// -----------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic issue(input logic [4:0] s, input logic [2:0] b,
		input logic [15:0] a, input int w);
		sdmrd_ctrl_model_i.cmd(s, b, a);
		repeat (w) @(negedge mclk);
	endtask
	task automatic mrs(input logic [2:0] b, input logic [15:0] a);
		issue(c_mrs, b, a, 8);
	endtask
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask
	task automatic print_verdict();
		$display("compares %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// watchdog against a hung run
	initial
	begin
		#50000;
		error_cnt++;
		print_verdict();
	end
	// main sequence
	initial
	begin
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		chk(7'({mpr_on, part_lost}), 7'h00);
		for (int i = 0; i < 8; i++)
		begin
			mrs(3'h2, 16'(i) << 3);
			chk(7'(cwl_clk), 7'h05 + 7'(i));
			chk(7'(wl_clk), 7'h05 + 7'(i));
		end
		mrs(3'h1, 16'h0010);
		chk(7'(wl_clk), 7'h0E);
		mrs(3'h2, 16'h0400);
		chk(7'(rtt_wr_eff), 7'h02);
		mrs(3'h1, 16'h0080);
		chk(7'(rtt_wr_eff), 7'h00);
		mrs(3'h1, 16'h0000);
		chk(7'(rtt_wr_eff), 7'h02);
		done("mode registers");
		for (int j = 0; j < 8; j++)
		begin
			cmd_a = {3'h0, j[1], 1'b0, j[2], 10'h0F0};
			issue(j[0] ? c_wr : c_rd, 3'(j), cmd_a, 3);
			chk(7'({wr_go, rd_go}), j[0] ? 7'h02 : 7'h01);
			chk(7'({chop4, auto_pre}), 7'({!j[1], j[2]}));
			chk(16'(acc_bank), 16'(j));
			chk(acc_addr, cmd_a);
			@(negedge mclk);
			chk(7'({wr_go, rd_go, burst_busy}), 7'h01);
		end
		for (int i = 0; i < 7; i++)
		begin
			issue(t_s[i], 3'h1, {5'h00, i[0], 10'h000}, 3);
			chk({act_go, pre_go, pre_all, ref_go, zq_go, zq_long, cmd_bad},
				t_e[i]);
		end
		issue(c_nop, 3'h0, 16'h0000, 3);
		chk(7'({sref_on, pdn_on}), 7'h00);
		done("commands");
		issue(c_pre, 3'h0, 16'h0400, 8);
		mrs(3'h3, 16'h0006);
		chk(7'({mpr_on, mpr_sel}), 7'h06);
		issue(c_rd, 3'h0, 16'h1000, 3);
		chk(7'({mpr_rd_go, rd_go}), 7'h02);
		mrs(3'h3, 16'h0001);
		chk(7'({mpr_on, mpr_sel}), 7'h02);
		mrs(3'h3, 16'h0004);
		chk(7'(mpr_on), 7'h01);
		sdmrd_ctrl_model_i.hit_reset(6);
		repeat (8) @(negedge mclk);
		chk(7'(mpr_on), 7'h00);
		done("readout mode");
		mrs(3'h2, 16'h00C1);
		chk(7'({asr_en, srt_en, part_lost, pasr_sel}), 7'h31);
		issue(c_sre, 3'h0, 16'h0000, 8);
		chk(7'({sref_on, part_lost}), 7'h03);
		issue(c_nop, 3'h0, 16'h0000, 8);
		chk(7'(sref_on), 7'h00);
		issue(5'h07, 3'h0, 16'h0000, 8);
		chk(7'(pdn_on), 7'h01);
		issue(c_nop, 3'h0, 16'h0000, 8);
		chk(7'(pdn_on), 7'h00);
		done("power states");
		print_verdict();
	end
endmodule // sdmrd_top_tb
